// *** hdl/lec_event_regs.v ***
// event status, mask and contrast registers behind an apb slave
// ============================================================
//
// Local design decision: register access over APB.
`default_nettype none
`include "lec_regs.vh"

module lec_event_regs (
  input  wire        core_clk_i,
  input  wire        rst_i,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        line_done_i,
  input  wire        last_line_i,
  input  wire        frame_done_i,
  input  wire        fifo_empty_i,
  input  wire        fifo_overrun_i,
  input  wire        dma_fault_i,
  output wire        irq_o,
  output wire        contrast_pwm_o
);

  // ==========================================================
  // apb decode: zero wait states, unmapped addresses error
  wire       wr_en;
  wire       rd_en;
  wire [6:0] wbits;
  reg        hit;

  assign pready = 1'b1;
  assign wr_en  = psel & penable & pwrite & ~pslverr;
  // reads load in the setup cycle so data stands at the access edge
  assign rd_en  = psel & ~penable & ~pwrite;
  assign wbits  = pwdata[6:0] & `LEC_EV_USED;

  always @* begin
    case (paddr)
      `LEC_ADDR_CONTRAST_CTRL: hit = 1'b1;
      `LEC_ADDR_CONTRAST_COMPARE_VALUE:  hit = 1'b1;
      `LEC_ADDR_EV_ENABLE_SET: hit = 1'b1;
      `LEC_ADDR_EV_ENABLE_CLR: hit = 1'b1;
      `LEC_ADDR_EV_MASK_VIEW:  hit = 1'b1;
      `LEC_ADDR_EV_PEND_VIEW:  hit = 1'b1;
      `LEC_ADDR_EV_PEND_CLR:   hit = 1'b1;
      default:                 hit = 1'b0;
    endcase
  end

  assign pslverr = psel & penable & ~hit;

  // ==========================================================
  // event sources: same-clock pulses from the dma and fifo logic
  wire [6:0] ev_in;

  assign ev_in = {dma_fault_i,
                  fifo_overrun_i, fifo_empty_i,
                  1'b0,
                  frame_done_i,
                  last_line_i, line_done_i};

  // ==========================================================
  // registers
  reg  [3:0] ctrl;
  reg  [7:0] compare;
  reg  [6:0] mask;
  reg  [6:0] pending;
  wire [6:0] next_mask;
  wire [6:0] next_pending;
  wire       sel_set;
  wire       sel_dis;
  wire       sel_clr;

  assign sel_set = wr_en & (paddr == `LEC_ADDR_EV_ENABLE_SET);
  assign sel_dis = wr_en & (paddr == `LEC_ADDR_EV_ENABLE_CLR);
  assign sel_clr = wr_en & (paddr == `LEC_ADDR_EV_PEND_CLR);

  // set and clear in one write cannot collide: they are separate words
  assign next_mask = (mask | ({7{sel_set}} & wbits))
                     & ~({7{sel_dis}} & wbits);

  // a new event beats a clear in the same cycle, so none is lost
  assign next_pending = (pending & ~({7{sel_clr}} & wbits))
                        | (ev_in & `LEC_EV_USED);

  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl    <= `LEC_RST_CTRL;
      compare <= `LEC_RST_CONTRAST_COMPARE;
      mask    <= `LEC_RST_EV;
      pending <= `LEC_RST_EV;
    end else begin
      mask    <= next_mask;
      pending <= next_pending;
      if (wr_en && paddr == `LEC_ADDR_CONTRAST_CTRL) begin
        ctrl <= pwdata[`LEC_CTL_RUN:0];
      end
      if (wr_en && paddr == `LEC_ADDR_CONTRAST_COMPARE_VALUE) begin
        compare <= pwdata[7:0];
      end
    end
  end

  // status stays set regardless of mask; only the output is gated
  assign irq_o = |(pending & mask);

  // ==========================================================
  // read data, registered in the setup cycle; write-only words read 0
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      case (paddr)
        `LEC_ADDR_CONTRAST_CTRL: prdata <= {28'h0, ctrl};
        `LEC_ADDR_CONTRAST_COMPARE_VALUE:  prdata <= {24'h0, compare};
        `LEC_ADDR_EV_MASK_VIEW:  prdata <= {25'h0, mask};
        `LEC_ADDR_EV_PEND_VIEW:  prdata <= {25'h0, pending};
        default:                 prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // contrast pwm
  lec_contrast_pwm #(
    .WIDTH (8)
  ) u_pwm (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .run_i      (ctrl[`LEC_CTL_RUN]),
    .polarity_i (ctrl[`LEC_CTL_POL]),
    .prescale_i (ctrl[`LEC_CTL_PS_MSB:`LEC_CTL_PS_LSB]),
    .compare_i  (compare),
    .pwm_o      (contrast_pwm_o)
  );

endmodule

`default_nettype wire

// *** hdl/lec_regs.vh ***
// register byte addresses, field positions and reset values of the event block
`ifndef LEC_REGS_VH
`define LEC_REGS_VH

// ============================================================
// byte addresses
`define LEC_ADDR_CONTRAST_CTRL 32'h0060_0840
`define LEC_ADDR_CONTRAST_COMPARE_VALUE  32'h0060_0844
`define LEC_ADDR_EV_ENABLE_SET 32'h0060_0848
`define LEC_ADDR_EV_ENABLE_CLR 32'h0060_084c
`define LEC_ADDR_EV_MASK_VIEW  32'h0060_0850
`define LEC_ADDR_EV_PEND_VIEW  32'h0060_0854
`define LEC_ADDR_EV_PEND_CLR   32'h0060_0858

// ============================================================
// event bit positions
`define LEC_EV_LINE      0
`define LEC_EV_LAST_LINE 1
`define LEC_EV_FRAME     2
`define LEC_EV_UNDERFLOW 4
`define LEC_EV_OVERWRITE 5
`define LEC_EV_DMA_FAULT 6
`define LEC_EV_USED      7'h77

// ============================================================
// contrast control fields
`define LEC_CTL_PS_LSB   0
`define LEC_CTL_PS_MSB   1
`define LEC_CTL_POL      2
`define LEC_CTL_RUN      3

// ============================================================
// reset values
`define LEC_RST_CTRL     4'h0
`define LEC_RST_CONTRAST_COMPARE     8'h00
`define LEC_RST_EV       7'h00

`endif

// *** hdl/lec_contrast_pwm.v ***
// contrast pwm counter with prescaler and polarity select
`default_nettype none

module lec_contrast_pwm #(
  parameter WIDTH = 8
) (
  input  wire             core_clk_i,
  input  wire             rst_i,
  input  wire             run_i,
  input  wire             polarity_i,
  input  wire [1:0]       prescale_i,
  input  wire [WIDTH-1:0] compare_i,
  output reg              pwm_o
);

  // ==========================================================
  // prescaler: one-cycle enable every 1, 2, 4 or 8 clocks
  reg  [2:0]       div;
  reg  [WIDTH-1:0] count;
  wire             tick;

  assign tick = (prescale_i == 2'h0) ? 1'b1 :
                (prescale_i == 2'h1) ? (div[0] == 1'b1) :
                (prescale_i == 2'h2) ? (div[1:0] == 2'h3) :
                (div == 3'h7);

  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      div   <= 3'h0;
      count <= {WIDTH{1'b0}};
      pwm_o <= 1'b0;
    end else begin
      // stopped counter keeps its value while run is low
      if (run_i) begin
        div <= div + 3'h1;
        if (tick) begin
          count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
        end
      end
      // active level while below compare; polarity picks that level
      pwm_o <= run_i & ((count < compare_i) ~^ polarity_i) |
               ~run_i & ~polarity_i;
    end
  end

endmodule

`default_nettype wire

// *** testbench/lec_props.sv ***
// assertion checker for the event register block
`default_nettype none
module lec_props (
  input wire logic        core_clk_i,
  input wire logic        rst_i,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        irq_o
);
  wire logic       acc = psel && penable;
  wire logic       rda = acc && !pwrite;
  wire logic       wra = acc && pwrite;
  wire logic [7:0] off = paddr[7:0];
  wire logic       bs  = paddr[31:8] == 24'h006008;
  wire logic       mp  = bs && off >= 8'h40 && off <= 8'h58 && !off[1:0];
  wire logic       wo  = bs && (off == 8'h48 || off == 8'h4c || off == 8'h58);
  // =====
  // properties
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  property p_err; acc && !mp |-> pslverr; endproperty
  a_err: assert property (p_err) else $error("no pslverr");
  property p_qt; !acc |-> !pslverr; endproperty
  a_qt: assert property (p_qt) else $error("stray pslverr");
  property p_unm; rda && !mp |-> prdata == 32'h0; endproperty
  a_unm: assert property (p_unm) else $error("unmapped data");
  property p_wo; rda && wo |-> prdata == 32'h0; endproperty
  a_wo: assert property (p_wo) else $error("write-only data");
  property p_cv; rda && mp && off == 8'h44 |-> !prdata[31:8]; endproperty
  a_cv: assert property (p_cv) else $error("compare width");
  property p_ly; rda && mp && off[7:3] == 5'h0a |-> !(prdata & 32'hffffff88);
  endproperty
  a_ly: assert property (p_ly) else $error("event layout");
  // read data must not drift between reads, software may sample it late
  property p_hd; !(psel && !penable && !pwrite) |=> $stable(prdata);
  endproperty
  a_hd: assert property (p_hd) else $error("prdata moved");
  property p_fl; $fell(irq_o) |-> $past(wra); endproperty
  a_fl: assert property (p_fl) else $error("irq fell alone");
  c_irq: cover property ($rose(irq_o));
  c_err: cover property (pslverr);
  c_wo: cover property (rda && wo);
endmodule
bind lec_event_regs lec_props u_props (.core_clk_i, .rst_i, .psel,
  .penable, .pwrite, .paddr, .prdata, .pslverr, .irq_o);
`default_nettype wire

// *** testbench/tb.sv ***
// self-checking bench for the event and contrast register block
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk_i = 1'b0;
  logic        rst_i      = 1'b1;
  logic        psel       = 1'b0;
  logic        penable    = 1'b0;
  logic        pwrite     = 1'b0;
  logic [31:0] paddr      = 32'h0;
  logic [31:0] pwdata     = 32'h0;
  logic [5:0]  ev         = 6'h0;
  logic [31:0] pend       = 32'h0;
  logic [31:0] prdata;
  logic [31:0] got;
  logic        err;
  logic        pready;
  logic        pslverr;
  logic        irq_o;
  logic        contrast_pwm_o;
  int          bad_count  = 0;
  int          n_tests    = 0;
  int          cyc        = 0;
  int          hi;
  always #4 core_clk_i = ~core_clk_i;
  lec_event_regs DUT (.core_clk_i, .rst_i, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .line_done_i(ev[0]),
    .last_line_i(ev[1]), .frame_done_i(ev[2]), .fifo_empty_i(ev[3]),
    .fifo_overrun_i(ev[4]), .dma_fault_i(ev[5]), .irq_o, .contrast_pwm_o);
  // =====
  // apb tasks
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= 32'h0060_0800 + a;
    pwdata  <= d;
    @(posedge core_clk_i);
    penable <= 1'b1;
    do @(posedge core_clk_i); while (pready !== 1'b1);
    got      = prdata;
    err      = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // read data stands at the access edge and is taken there
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(got, e);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      results();
    end
  end
  // =====
  // scenarios
  initial begin
    repeat (4) @(posedge core_clk_i);
    rst_i <= 1'b0;
    @(posedge core_clk_i);
    rd(8'h44, 32'h0);
    rd(8'h50, 32'h0);
    wr(8'h44, 32'h1a5);
    rd(8'h44, 32'ha5);
    wr(8'h48, 32'h5);
    wr(8'h48, 32'hfffffff0);
    rd(8'h50, 32'h75);
    wr(8'h4c, 32'h1c);
    rd(8'h50, 32'h61);
    rd(8'h48, 32'h0);
    chk({31'h0, err}, 32'h0);
    rd(8'h60, 32'h0);
    chk({31'h0, err}, 32'h1);
    rd(8'h40, 32'h0);
    for (int i = 0; i < 6; i++) begin
      ev[i] <= 1'b1;
      @(posedge core_clk_i);
      ev[i] <= 1'b0;
      pend = pend | (i < 3 ? 1 << i : 1 << (i + 1));
      rd(8'h54, pend);
    end
    chk({31'h0, irq_o}, 32'h1);
    wr(8'h58, 32'h3);
    rd(8'h54, 32'h74);
    wr(8'h4c, 32'h60);
    chk({31'h0, irq_o}, 32'h0);
    wr(8'h58, 32'h0);
    rd(8'h54, 32'h74);
    wr(8'h58, 32'h70);
    wr(8'h48, 32'h4);
    chk({31'h0, irq_o}, 32'h1);
    wr(8'h58, 32'h4);
    chk({31'h0, irq_o}, 32'h0);
    wr(8'h44, 32'h80);
    for (int p = 0; p < 4; p++) begin
      wr(8'h40, 32'hc | p);
      repeat (40) @(posedge core_clk_i);
      hi = 0;
      repeat (256 << p) begin
        @(posedge core_clk_i);
        hi += contrast_pwm_o;
      end
      chk(hi, 128 << p);
    end
    wr(8'h40, 32'h4);
    repeat (3) @(posedge core_clk_i);
    chk({31'h0, contrast_pwm_o}, 32'h0);
    wr(8'h40, 32'h0);
    repeat (3) @(posedge core_clk_i);
    chk({31'h0, contrast_pwm_o}, 32'h1);
    results();
  end
endmodule
`default_nettype wire
